//--- rtl/tcc_edge.sv
// Shared constants and the timer input synchroniser with edge detection
package tcc_pkg;
  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_COUNT    = 8'h04;
  localparam logic [7:0]  ADDR_RELOAD   = 8'h08;
  localparam logic [7:0]  ADDR_INT_STAT = 8'h0C;
  localparam logic [7:0]  ADDR_INT_CLR  = 8'h10;
  localparam logic [7:0]  ADDR_INT_ENA  = 8'h14;
  localparam logic [7:0]  ADDR_PIN      = 8'h18;
  // Control field positions
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_MODE_LO  = 1;
  localparam int          CTRL_MODE_HI  = 2;
  localparam int          CTRL_PS_LO    = 3;
  localparam int          CTRL_PS_HI    = 5;
  localparam int          CTRL_POL_BIT  = 6;
  localparam int          CTRL_OUTE_BIT = 7;
  // Mode encodings
  localparam logic [1:0]  MODE_ONESHOT  = 2'h0;
  localparam logic [1:0]  MODE_CONT     = 2'h1;
  localparam logic [1:0]  MODE_COUNTER  = 2'h2;
  // Reset values
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0001;
  localparam logic [15:0] RELOAD_RESET  = 16'hFFFF;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [7:0]  INT_ENA_RESET = 8'h00;
  // Interrupt status bit of the reload event
  localparam int          INT_RELOAD_BIT = 0;
endpackage : tcc_pkg

////////////////////////////////////////////////////////////////////////////////

module tcc_edge (
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  input  wire logic pin_i,
  input  wire logic falling_sel,
  output logic      edge_pulse
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // Two-stage synchroniser, then edge history
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Polarity picks rising or falling edge
  assign edge_pulse = falling_sel ? (prev_r & ~sync2_r) : (~prev_r & sync2_r);
endmodule : tcc_edge

//--- rtl/tcc_timer.sv
// 16-bit timer with one-shot, continuous and counter modes on a Wishbone slave
// How it works
// - Continuous mode counts up until the count equals the 16-bit reload value.
// - Continuous match raises interrupt, restarts count at 0001H, keeps counting.
// - With output enabled, the timer pin inverts at every reload in both modes.
// - Continuous mode counts prescaled clock ticks: period is reload times prescale.
// - One-shot counts prescaled ticks from start value up to reload.
// - Software start count applies to the first pass only; later passes restart at 0001H.
// - A start value above 0001H and up to the reload value shortens the first period accordingly.
// - Counter mode advances on timer input pin transitions, not the clock.
// - Polarity bit chooses rising or falling input edge in counter mode.
// - Counter mode bypasses the prescaler: one edge, one count.
// - In counter mode the polarity bit also sets the initial output level.
// - Counter match raises interrupt, restarts count at 0001H, keeps counting edges.
// - In counter mode, until the first match, edges seen equal current count minus start value.
// - The pin is input in counter mode, output otherwise when the output enable bit is set.
// - Reset sets count to 0001H and reload to FFFFH.
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        TMR_PIN_I,
  output logic             TMR_PIN_O,
  output logic             TMR_PIN_OE_N,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  ctrl_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic [7:0]  int_stat_r;
  logic [7:0]  int_ena_r;
  logic [7:0]  presc_r;
  logic        out_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        bus_req;
  logic        wr_req;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_reload;
  logic        wr_iclr;
  logic        wr_iena;
  logic        enabled;
  logic [1:0]  mode;
  logic [2:0]  ps_sel;
  logic        polarity;
  logic        out_func;
  logic        is_counter;
  logic        presc_tick;
  logic        in_edge;
  logic        advance;
  logic        match;
  logic        reload_evt;
  logic [7:0]  presc_limit;
  logic [7:0]  reload_set;

  ////////////////////////////////////////////////////////////////////////////
  // Control field decode
  assign enabled    = ctrl_r[CTRL_EN_BIT];
  assign mode       = ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO];
  assign ps_sel     = ctrl_r[CTRL_PS_HI:CTRL_PS_LO];
  assign polarity   = ctrl_r[CTRL_POL_BIT];
  assign out_func   = ctrl_r[CTRL_OUTE_BIT];
  assign is_counter = (mode == MODE_COUNTER);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait cycle, ack for one cycle
  assign bus_req   = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr_req    = bus_req & WB_WE_I;
  assign wr_ctrl   = wr_req & (WB_ADR_I == ADDR_CTRL) & WB_SEL_I[0];
  assign wr_count  = wr_req & (WB_ADR_I == ADDR_COUNT);
  assign wr_reload = wr_req & (WB_ADR_I == ADDR_RELOAD);
  assign wr_iclr   = wr_req & (WB_ADR_I == ADDR_INT_CLR) & WB_SEL_I[0];
  assign wr_iena   = wr_req & (WB_ADR_I == ADDR_INT_ENA) & WB_SEL_I[0];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_req && !WB_WE_I) begin
      case (WB_ADR_I)
        ADDR_CTRL:     rdata_r <= {24'h00_0000, ctrl_r};
        ADDR_COUNT:    rdata_r <= {16'h0000, count_r};
        ADDR_RELOAD:   rdata_r <= {16'h0000, reload_r};
        ADDR_INT_STAT: rdata_r <= {24'h00_0000, int_stat_r};
        ADDR_INT_ENA:  rdata_r <= {24'h00_0000, int_ena_r};
        ADDR_PIN:      rdata_r <= {30'h0000_0000, TMR_PIN_OE_N, out_r};
        default:       rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control and reload registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= WB_DAT_I[7:0];
    end else if (reload_evt && mode == MODE_ONESHOT) begin
      ctrl_r[CTRL_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      reload_r <= RELOAD_RESET;
    end else if (wr_reload) begin
      if (WB_SEL_I[0]) reload_r[7:0]  <= WB_DAT_I[7:0];
      if (WB_SEL_I[1]) reload_r[15:8] <= WB_DAT_I[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: divide by 2**ps_sel, held clear while disabled
  assign presc_limit = 8'((9'h001 << ps_sel) - 9'h001);
  assign presc_tick  = (presc_r == presc_limit);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      presc_r <= 8'h00;
    end else if (!enabled || is_counter || presc_tick) begin
      presc_r <= 8'h00;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer input edges from the pin
  tcc_edge u_edge (
    .SYS_CLK     (SYS_CLK),
    .RST_N       (RST_N),
    .pin_i       (TMR_PIN_I),
    .falling_sel (polarity),
    .edge_pulse  (in_edge)
  );

  // Counter mode takes pin edges with no prescaling
  assign advance    = enabled & (is_counter ? in_edge : presc_tick);
  assign match      = (count_r == reload_r);
  assign reload_evt = advance & match;

  ////////////////////////////////////////////////////////////////////////////
  // Count register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      count_r <= COUNT_RESET;
    end else if (wr_count) begin
      // Start value holds for the first pass only
      if (WB_SEL_I[0]) count_r[7:0]  <= WB_DAT_I[7:0];
      if (WB_SEL_I[1]) count_r[15:8] <= WB_DAT_I[15:8];
    end else if (reload_evt) begin
      count_r <= COUNT_RESTART;
    end else if (advance) begin
      count_r <= count_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer output level and pin direction
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      out_r <= 1'b0;
    end else if (wr_ctrl && !WB_DAT_I[CTRL_EN_BIT]) begin
      out_r <= WB_DAT_I[CTRL_POL_BIT];
    end else if (reload_evt && out_func) begin
      out_r <= ~out_r;
    end
  end

  assign TMR_PIN_O    = out_r;
  // Pin is driven only as timer output outside counter mode
  assign TMR_PIN_OE_N = ~(out_func & ~is_counter);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear; a new event wins over a clear
  assign reload_set = {7'h00, reload_evt};

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      int_stat_r <= 8'h00;
    end else begin
      int_stat_r <= ((wr_iclr ? (int_stat_r & ~WB_DAT_I[7:0]) : int_stat_r) | reload_set);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      int_ena_r <= INT_ENA_RESET;
    end else if (wr_iena) begin
      int_ena_r <= WB_DAT_I[7:0];
    end
  end

  assign IRQ = |(int_stat_r & int_ena_r);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_wrap;
    reload_evt && !wr_count;
  endsequence

  sequence s_restart;
    ##1 count_r == COUNT_RESTART;
  endsequence

  a_reload_wrap: assert property (s_wrap |-> s_restart)
    else $error("count did not restart after reload");

  a_count_step: assert property (advance && !match && !wr_count |=> count_r == $past(count_r) + 16'h0001)
    else $error("count did not step by one");

  a_out_toggle: assert property (reload_evt && out_func && !wr_ctrl |=> out_r != $past(out_r))
    else $error("timer output did not invert at reload");

  a_count_frozen: assert property (!enabled && !wr_count |=> $stable(count_r))
    else $error("count moved while disabled");

  a_irq_raise: assert property (reload_evt && int_ena_r[INT_RELOAD_BIT] && !wr_iena |=> int_stat_r[INT_RELOAD_BIT] && IRQ)
    else $error("reload did not raise interrupt");

  a_presc_four: assert property (enabled && mode == MODE_CONT && ps_sel == 3'h2 && presc_tick && !wr_ctrl
                                 |=> !presc_tick [*3] ##1 (presc_tick || !enabled))
    else $error("divide by four prescaler spacing wrong");

  a_edge_count: assert property (enabled && is_counter && in_edge |-> advance)
    else $error("counter mode edge did not advance count");

  a_clock_ignored: assert property (enabled && is_counter && !in_edge && !wr_count |=> $stable(count_r))
    else $error("counter mode advanced without an input edge");

  a_pin_input: assert property (is_counter |-> TMR_PIN_OE_N)
    else $error("pin driven in counter mode");

  a_init_level: assert property (wr_ctrl && !WB_DAT_I[CTRL_EN_BIT] |=> out_r == $past(WB_DAT_I[CTRL_POL_BIT]))
    else $error("initial output level not taken from polarity");

  a_oneshot_stop: assert property (reload_evt && mode == MODE_ONESHOT && !wr_ctrl |=> !enabled)
    else $error("one-shot did not stop at reload");

  // Bus handshake and register access
  sequence s_bus_take;
    bus_req;
  endsequence

  sequence s_ack_once;
    ##1 WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  sequence s_oneshot_end;
    reload_evt && mode == MODE_ONESHOT && !wr_count;
  endsequence

  a_ack_pulse: assert property (s_bus_take |-> s_ack_once)
    else $error("ack not a single cycle pulse after request");

  a_ack_only_req: assert property (!WB_CYC_I || !WB_STB_I |=> !WB_ACK_O)
    else $error("ack without a request");

  a_read_count: assert property (bus_req && !WB_WE_I && WB_ADR_I == ADDR_COUNT |=> WB_DAT_O == {16'h0000, $past(count_r)})
    else $error("count read data wrong");

  a_read_reload: assert property (bus_req && !WB_WE_I && WB_ADR_I == ADDR_RELOAD |=> WB_DAT_O == {16'h0000, $past(reload_r)})
    else $error("reload read data wrong");

  a_read_stat: assert property (bus_req && !WB_WE_I && WB_ADR_I == ADDR_INT_STAT |=> WB_DAT_O == {24'h00_0000, $past(int_stat_r)})
    else $error("status read data wrong");

  a_read_ctrl: assert property (bus_req && !WB_WE_I && WB_ADR_I == ADDR_CTRL |=> WB_DAT_O == {24'h00_0000, $past(ctrl_r)})
    else $error("control read data wrong");

  a_rdata_hold: assert property (!(bus_req && !WB_WE_I) |=> $stable(WB_DAT_O))
    else $error("read data changed without a read");

  a_ctrl_write: assert property (wr_ctrl |=> ctrl_r == $past(WB_DAT_I[7:0]))
    else $error("control write lost");

  a_ena_write: assert property (wr_iena |=> int_ena_r == $past(WB_DAT_I[7:0]))
    else $error("interrupt enable write lost");

  a_count_write: assert property (wr_count && WB_SEL_I[1:0] == 2'h3 |=> count_r == $past(WB_DAT_I[15:0]))
    else $error("count write lost");

  a_reload_write: assert property (wr_reload && WB_SEL_I[1:0] == 2'h3 |=> reload_r == $past(WB_DAT_I[15:0]))
    else $error("reload write lost");

  // Interrupt status, output, prescaler and count advance
  a_stat_set: assert property (reload_evt |=> int_stat_r[INT_RELOAD_BIT])
    else $error("reload event lost against a clear");

  a_stat_clear: assert property (wr_iclr && WB_DAT_I[INT_RELOAD_BIT] && !reload_evt |=> !int_stat_r[INT_RELOAD_BIT])
    else $error("status bit not cleared");

  a_stat_hold: assert property (!reload_evt && !wr_iclr |=> $stable(int_stat_r))
    else $error("status changed without event or clear");

  a_out_hold: assert property (!reload_evt && !wr_ctrl |=> $stable(out_r))
    else $error("timer output changed without reload");

  a_oe_driven: assert property (out_func && !is_counter |-> !TMR_PIN_OE_N)
    else $error("pin not driven as timer output");

  a_presc_bypass: assert property (is_counter |=> presc_r == 8'h00)
    else $error("prescaler ran in counter mode");

  a_presc_hold: assert property (!enabled |=> presc_r == 8'h00)
    else $error("prescaler ran while disabled");

  a_no_adv_off: assert property (!enabled |-> !advance)
    else $error("count advanced while disabled");

  a_oneshot_restart: assert property (s_oneshot_end |-> s_restart)
    else $error("one-shot count did not restart");

endmodule : tcc_timer

//--- sim/tcc_pin_model.sv
// External source that toggles the timer input pin a requested number of times
module tcc_pin_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] num,
  output logic            pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_r;
  logic [1:0] gap_r;
  // One toggle every 4 clocks, never faster than a quarter of the clock rate
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      left_r <= 8'h00;
      gap_r  <= 2'h0;
      pin    <= 1'b0;
    end else if (start) begin
      left_r <= num;
      gap_r  <= 2'h0;
    end else if (left_r != 8'h00) begin
      gap_r <= gap_r + 2'h1;
      if (gap_r == 2'h3) begin
        pin    <= ~pin;
        left_r <= left_r - 8'h01;
      end
    end
  end
  assign busy = (left_r != 8'h00);
endmodule : tcc_pin_model

//--- sim/tcc_timer_tb.sv
// Self-checking bench of the timer: bus tasks, scoreboard, pin source
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tcc_timer_tb;
  import tcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        SYS_CLK, RST_N, cyc, stb, we, p_start, p_busy, p_pin, last_o;
  logic [7:0]  adr, p_num;
  logic [3:0]  sel;
  logic [31:0] dat, WB_DAT_O, rnd, exp_q[$];
  logic        WB_ACK_O, TMR_PIN_O, TMR_PIN_OE_N, IRQ;
  int          bad_count, n_tests, cyc_n, tq[$], r, sz, st;
  initial begin
    SYS_CLK = 1'b0; RST_N = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'h0; dat = 32'h0; p_start = 1'b0; p_num = 8'h00;
    last_o = 1'b0; bad_count = 0; n_tests = 0; cyc_n = 0; rnd = 32'hC3E1;
  end
  always #4 SYS_CLK = ~SYS_CLK;
  tcc_timer dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .TMR_PIN_I(p_pin), .TMR_PIN_O(TMR_PIN_O), .TMR_PIN_OE_N(TMR_PIN_OE_N), .IRQ(IRQ));
  tcc_pin_model src (.sys_clk(SYS_CLK), .rst_n(RST_N), .start(p_start), .num(p_num),
    .pin(p_pin), .busy(p_busy));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    do @(posedge SYS_CLK); while (WB_ACK_O !== 1'b1 && ++n < 100);
    if (n >= 100) bad_count++;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Scoreboard takes the oldest read note at each read answer
  always @(posedge SYS_CLK) begin
    cyc_n++;
    if (TMR_PIN_O !== last_o) tq.push_back(cyc_n);
    last_o = TMR_PIN_O;
    if (WB_ACK_O === 1'b1 && cyc && !we && exp_q.size() > 0) `CHK(WB_DAT_O, exp_q.pop_front())
  end
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rd(ADDR_COUNT, 32'h0001);
    rd(ADDR_RELOAD, 32'hFFFF);
    rd(ADDR_CTRL, 32'h0); rd(ADDR_INT_ENA, 32'h0); rd(8'h1C, 32'h0);
    wb(1'b1, ADDR_INT_STAT, 32'h1); rd(ADDR_INT_STAT, 32'h0);
    $display("Test reset values done");
    // Continuous, prescale 4, random reload, start value 5
    rnd = lfsr(rnd); r = 8 + int'(rnd[2:0]);
    wb(1'b1, ADDR_CTRL, 32'h92); wb(1'b1, ADDR_COUNT, 32'h5); wb(1'b1, ADDR_RELOAD, r);
    wb(1'b1, ADDR_INT_ENA, 32'h1); tq.delete(); wb(1'b1, ADDR_CTRL, 32'h93);
    @(negedge SYS_CLK); st = cyc_n;
    for (int i = 0; i < 2000 && tq.size() < 3; i++) @(posedge SYS_CLK);
    `CHK(tq.size(), 3)
    `CHK(tq[2] - tq[1], r * 4)
    `CHK(tq[1] - tq[0], r * 4)
    `CHK(tq[0] - st, (r - 4) * 4)
    `CHK(IRQ, 1'b1)
    `CHK(TMR_PIN_OE_N, 1'b0)
    rd(ADDR_INT_STAT, 32'h1);
    wb(1'b1, ADDR_INT_CLR, 32'h1);
    `CHK(IRQ, 1'b0)
    $display("Test continuous done");
    wb(1'b1, ADDR_CTRL, 32'h92); wb(1'b1, ADDR_COUNT, 32'h7);
    repeat (2) @(posedge SYS_CLK);
    sz = tq.size();
    repeat (60) @(posedge SYS_CLK);
    rd(ADDR_COUNT, 32'h7);
    `CHK(tq.size(), sz)
    $display("Test freeze done");
    // Counter mode on both edges: 16 toggles give 8 counted edges, reload 5
    for (int pol = 0; pol < 2; pol++) begin
      wb(1'b1, ADDR_CTRL, 32'h84 | (pol << 6));
      repeat (2) @(posedge SYS_CLK);
      `CHK(TMR_PIN_O, pol[0])
      `CHK(TMR_PIN_OE_N, 1'b1)
      wb(1'b1, ADDR_COUNT, 32'h1); wb(1'b1, ADDR_RELOAD, 32'h5);
      wb(1'b1, ADDR_INT_CLR, 32'h1); wb(1'b1, ADDR_CTRL, 32'h85 | (pol << 6));
      p_num <= 8'd16; p_start <= 1'b1;
      @(posedge SYS_CLK);
      p_start <= 1'b0;
      @(posedge SYS_CLK);
      for (int i = 0; i < 200 && p_busy; i++) @(posedge SYS_CLK);
      repeat (8) @(posedge SYS_CLK);
      rd(ADDR_COUNT, 32'h4);
      rd(ADDR_INT_STAT, 32'h1);
      `CHK(TMR_PIN_O, ~pol[0])
      `CHK(IRQ, 1'b1)
    end
    $display("Test counter done");
    // One-shot, prescale 1, start 3, reload 10: eight ticks, then the timer stops
    wb(1'b1, ADDR_CTRL, 32'h80); wb(1'b1, ADDR_COUNT, 32'h3); wb(1'b1, ADDR_RELOAD, 32'hA);
    wb(1'b1, ADDR_INT_CLR, 32'h1); tq.delete(); wb(1'b1, ADDR_CTRL, 32'h81);
    @(negedge SYS_CLK); st = cyc_n;
    repeat (40) @(posedge SYS_CLK);
    `CHK(tq.size(), 1)
    `CHK(tq[0] - st, 8)
    rd(ADDR_CTRL, 32'h80);
    rd(ADDR_COUNT, 32'h1);
    rd(ADDR_INT_STAT, 32'h1);
    $display("Test one-shot done");
    finish_test();
  end
endmodule : tcc_timer_tb
